// >>> dv/tws_master_model.sv
// Behavioural bus master driving SCL and sharing SDA with the slave.
// Assumes pull-ups on both lines; one SCL period is 125 ns.
`timescale 1ns/10ps
`default_nettype none
module tws_master_model (
  output logic      scl,
  output wire logic sda,
  input  wire logic dev_oe
);
  localparam real Q = 31.25;
  logic pull = 1'h0;
  initial scl = 1'h1;
  // Either party pulling wins; a released line floats to the pull-up level.
  assign sda = (pull || dev_oe) ? 1'h0 : 1'h1;
  // SDA moves while SCL is high: falling for a start, rising for a stop.
  task automatic condition(input logic is_stop);
    scl = 1'h0;
    #Q pull = is_stop;
    #Q scl = 1'h1;
    #(2 * Q) pull = !is_stop;
    #(2 * Q);
  endtask
  // Eight data bits then the acknowledge slot; a released bit reads back what the slave drives.
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic got);
    logic [8:0] v;
    v = {tx, !ack};
    for (int i = 8; i >= 0; i--) begin
      scl = 1'h0;
      #Q pull = !v[i];
      #Q scl = 1'h1;
      #Q v[i] = sda;
      #Q;
    end
    rx = v[8:1];
    got = !v[0];
  endtask
endmodule
`default_nettype wire

// >>> dv/tws_slave_monitor.sv
// Port checker for tws_slave, attached by the bind below.
// Assumes SCL phases of several CLK periods.
`timescale 1ns/10ps
`default_nettype none
module tws_slave_monitor (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       ADDRESS_SELECT_PIN,
  input wire logic       WR_VALID,
  input wire logic       WR_READY,
  input wire logic [7:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  reset_clear_a: assert property ($fell(SYS_RST) |-> !BUSY && !SDA_OE && !WR_VALID)
    else $error("outputs not clear after reset");
  open_drain_a: assert property (SDA_OUT == 1'h0)
    else $error("SDA value not low");
  idle_release_a: assert property (!BUSY |-> !SDA_OE)
    else $error("SDA driven while idle");
  // The pins pass a synchroniser, so the drive may land just after the raw SCL rise.
  scl_low_change_a: assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2))
    else $error("SDA changed with SCL high");
  start_busy_a: assert property ($fell(SDA_IN) && SCL_IN && !BUSY |-> ##[1:8] BUSY)
    else $error("start missed");
  stop_idle_a: assert property ($rose(SDA_IN) && SCL_IN && !$past(SDA_OE) |-> ##[1:8] !BUSY)
    else $error("stop missed");
  push_ack_a: assert property ($rose(WR_VALID) |-> ##[0:4] SDA_OE)
    else $error("stored byte not acknowledged");
  head_hold_a: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_ADDR) && $stable(WR_DATA))
    else $error("head changed while stalled");
endmodule
bind tws_slave tws_slave_monitor tws_slave_monitor_i (.CLK(CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
  .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .BUSY(BUSY));
`default_nettype wire

// >>> dv/tws_slave_tb_top.sv
// Self-checking bench: random and corner transfers through the master model.
// Assumes the checker binds itself to tws_slave.
`timescale 1ns/10ps
`default_nettype none
module tws_slave_tb_top;
  logic        CLK = 1'h0;
  logic        SYS_RST = 1'h1;
  logic        ADDRESS_SELECT_PIN;
  logic        WR_READY;
  logic        hold = 1'h0;
  logic        SDA_OUT;
  logic        SDA_OE;
  logic        WR_VALID;
  logic        BUSY;
  logic [7:0]  WR_ADDR;
  logic [7:0]  WR_DATA;
  logic [7:0]  mem [256] = '{default: 8'h0};
  logic [15:0] exp_q [$];
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          seed = 32'h23AA;
  wire         SCL_IN;
  wire         SDA_IN;

  always #5 CLK = ~CLK;

  tws_slave #(.FIFO_DEPTH(8)) tws_slave_i (.CLK(CLK), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN), .WR_VALID(WR_VALID),
    .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .BUSY(BUSY));
  tws_master_model tws_master_model_i (.scl(SCL_IN), .sda(SDA_IN), .dev_oe(SDA_OE));

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end

  // The head is compared at the falling edge, where it stands settled before the popping edge.
  always @(negedge CLK) begin
    if (WR_VALID === 1'h1 && WR_READY === 1'h1) begin
      chk(exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, {WR_ADDR, WR_DATA});
    end
  end

  // Random pops give the FIFO both stalls and back-to-back reads.
  always @(posedge CLK) begin
    #1 WR_READY = !hold && 1'($random(seed));
  end

  function automatic logic [6:0] own(input logic s);
    return {tws_pkg::OWN_ADDR_HI, s};
  endfunction

  task automatic send(input logic [7:0] b, input logic e);
    logic [7:0] r;
    logic       k;
    tws_master_model_i.xfer(b, 1'h0, r, k);
    chk(16'(e), 16'(k));
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] p, input int n, input int room);
    logic [7:0] d;
    logic       e;
    tws_master_model_i.condition(1'h0);
    send({ad, 1'h0}, ad == own(ADDRESS_SELECT_PIN));
    if (ad == own(ADDRESS_SELECT_PIN)) begin
      send(p, 1'h1);
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        e = i < room;
        if (e) begin
          exp_q.push_back({8'(p + i), d});
          mem[8'(p + i)] = d;
        end
        send(d, e);
      end
    end
    tws_master_model_i.condition(1'h1);
  endtask

  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] r;
    logic       k;
    tws_master_model_i.condition(1'h0);
    send({own(ADDRESS_SELECT_PIN), 1'h0}, 1'h1);
    send(p, 1'h1);
    tws_master_model_i.condition(1'h0);
    send({own(ADDRESS_SELECT_PIN), 1'h1}, 1'h1);
    for (int i = 0; i < n; i++) begin
      tws_master_model_i.xfer(8'hFF, 1'(i < n - 1), r, k);
      chk(16'(mem[8'(p + i)]), 16'(r));
    end
    tws_master_model_i.condition(1'h1);
  endtask

  task automatic drain;
    repeat (3000) if (exp_q.size() != 0 || WR_VALID !== 1'h0) @(posedge CLK);
    chk(16'(exp_q.size()), 16'h0);
  endtask

  initial begin
    logic [7:0] p;
    int         n;
    ADDRESS_SELECT_PIN = 1'h0;
    repeat (6) @(posedge CLK);
    #1 SYS_RST = 1'h0;
    repeat (8) @(posedge CLK);
    for (int s = 0; s < 2; s++) begin
      @(posedge CLK);
      #1 ADDRESS_SELECT_PIN = s[0];
      repeat (8) @(posedge CLK);
      wr(own(!s[0]), 8'h00, 0, 0);
      for (int t = 0; t < 4; t++) begin
        p = 8'($random(seed));
        n = 1 + ($random(seed) & 3);
        wr(own(s[0]), p, n, 256);
        rd(p, n);
      end
    end
    // The pointer runs past the top of the map and wraps.
    wr(own(1'h1), 8'hFE, 4, 256);
    rd(8'hFE, 4);
    drain();
    hold = 1'h1;
    wr(own(1'h1), 8'h40, 9, 8);
    hold = 1'h0;
    drain();
    rd(8'h40, 8);
    chk(16'(BUSY), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire

// >>> src/tws_fifo.sv
// Small synchronous FIFO carrying written register bytes to the user side.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/10ps
`default_nettype none
module tws_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= '0;
      end
    end else if (in_valid && !full) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> src/tws_pkg.sv
// Shared constants and types for the two-wire register port slave.
// Assumes a single 100 MHz system clock; the bus pins are asynchronous to it.
package tws_pkg;

  // Fixed upper six bits of the slave address; the lowest bit comes from a pin.
  localparam logic [5:0] OWN_ADDR_HI  = 6'h26;
  localparam int         BYTE_BITS    = 8;
  localparam logic [3:0] BITS_IN_BYTE = 4'h8;
  localparam int         REG_AW       = 8;
  localparam int         FIFO_DEPTH   = 8;
  localparam logic       DIR_READ     = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_PTR       = 4'b0011,
    ST_PTR_ACK   = 4'b0100,
    ST_WDATA     = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA     = 4'b0111,
    ST_RACK      = 4'b1000
  } tws_state_t;

endpackage

// >>> src/tws_regmem.sv
// Register image seen by bus reads: one write port, registered read port.
// Assumes one clock; every entry clears to zero at reset.
`timescale 1ns/10ps
`default_nettype none
module tws_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        cells[i] <= '0;
      end
    end else if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule
`default_nettype wire

// >>> src/tws_slave.sv
// Two-wire serial register port, slave side, with write stream and register image.
// Assumes SCL and SDA are open-drain pins with external pull-ups, sampled by CLK.
`timescale 1ns/10ps
`default_nettype none
module tws_slave #(
  parameter int FIFO_DEPTH = tws_pkg::FIFO_DEPTH
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       ADDRESS_SELECT_PIN,
  output logic            WR_VALID,
  input  wire logic       WR_READY,
  output logic      [7:0] WR_ADDR,
  output logic      [7:0] WR_DATA,
  output logic            BUSY
);
  logic [2:0]          scl_sync;
  logic [2:0]          sda_sync;
  logic [2:0]          asel_sync;
  logic                scl_f;
  logic                sda_f;
  logic                asel_f;
  logic                scl_rise;
  logic                scl_fall;
  logic                is_start;
  logic                is_stop;
  tws_pkg::tws_state_t state;
  logic [3:0]          cnt;
  logic [7:0]          shift;
  logic [7:0]          tx;
  logic [7:0]          ptr;
  logic                rw;
  logic                master_ack;
  logic                oe;
  logic                byte_end;
  logic                addr_match;
  logic                push;
  logic                fifo_ready;
  logic [7:0]          rd_data;
  logic [15:0]         fifo_out;
  logic                bus_cond;
  logic                take_bit;
  logic                addr_hit;
  logic                load_tx;

  // Two synchroniser stages that agree mark a level that has settled.
  function automatic logic settled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  function automatic logic receiving(input tws_pkg::tws_state_t s);
    return (s == tws_pkg::ST_ADDR) || (s == tws_pkg::ST_PTR) || (s == tws_pkg::ST_WDATA);
  endfunction

  // Open-drain: the output level is always low, only the enable moves.
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = oe;
  assign BUSY    = (state != tws_pkg::ST_IDLE);

  // Three-stage sampling; a change counts only when stages two and three agree.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sda_sync <= 3'h7;
    end else begin
      sda_sync <= {sda_sync[1:0], SDA_IN};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      asel_sync <= 3'h0;
    end else begin
      asel_sync <= {asel_sync[1:0], ADDRESS_SELECT_PIN};
    end
  end

  // Filtered bus levels start high like the pulled-up lines, so no false edge follows reset.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_f <= 1'b1;
    end else if (settled(scl_sync)) begin
      scl_f <= scl_sync[2];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sda_f <= 1'b1;
    end else if (settled(sda_sync)) begin
      sda_f <= sda_sync[2];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      asel_f <= 1'b0;
    end else if (settled(asel_sync)) begin
      asel_f <= asel_sync[2];
    end
  end

  assign scl_rise = !scl_f && settled(scl_sync) && scl_sync[2];
  assign scl_fall = scl_f && settled(scl_sync) && !scl_sync[2];

  // An SDA edge while SCL stays high is a bus condition, not data.
  assign is_start = scl_f && !scl_fall && sda_f && settled(sda_sync) && !sda_sync[2];
  assign is_stop  = scl_f && !scl_fall && !sda_f && settled(sda_sync) && sda_sync[2];
  assign bus_cond = is_start || is_stop;

  assign byte_end   = scl_fall && (cnt == tws_pkg::BITS_IN_BYTE);
  assign addr_match = (shift[7:1] == {tws_pkg::OWN_ADDR_HI, asel_f});
  assign take_bit   = !bus_cond && receiving(state) && scl_rise && (cnt < tws_pkg::BITS_IN_BYTE);
  assign addr_hit   = !bus_cond && (state == tws_pkg::ST_ADDR) && byte_end && addr_match;

  // A full stream buffer withholds the acknowledge instead of losing a byte.
  assign push = (state == tws_pkg::ST_WDATA) && byte_end && fifo_ready && !bus_cond;

  // A read byte is fetched only when the slot just closed leads into more read data.
  assign load_tx = !bus_cond && scl_fall && (((state == tws_pkg::ST_ADDR_ACK) && (rw == tws_pkg::DIR_READ)) ||
                                             ((state == tws_pkg::ST_RACK) && master_ack));

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= tws_pkg::ST_IDLE;
    end else if (is_start) begin
      state <= tws_pkg::ST_ADDR;
    end else if (is_stop) begin
      state <= tws_pkg::ST_IDLE;
    end else begin
      case (state)
        tws_pkg::ST_IDLE: begin
          state <= tws_pkg::ST_IDLE;
        end
        tws_pkg::ST_ADDR: begin
          if (byte_end) begin
            state <= addr_match ? tws_pkg::ST_ADDR_ACK : tws_pkg::ST_IDLE;
          end
        end
        tws_pkg::ST_PTR: begin
          if (byte_end) begin
            state <= tws_pkg::ST_PTR_ACK;
          end
        end
        tws_pkg::ST_WDATA: begin
          if (byte_end) begin
            state <= push ? tws_pkg::ST_WDATA_ACK : tws_pkg::ST_IDLE;
          end
        end
        tws_pkg::ST_ADDR_ACK: begin
          // Entered on the eighth falling edge, so the next fall closes the ninth pulse.
          if (scl_fall) begin
            state <= (rw == tws_pkg::DIR_READ) ? tws_pkg::ST_RDATA : tws_pkg::ST_PTR;
          end
        end
        tws_pkg::ST_PTR_ACK, tws_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            state <= tws_pkg::ST_WDATA;
          end
        end
        tws_pkg::ST_RDATA: begin
          if (byte_end) begin
            state <= tws_pkg::ST_RACK;
          end
        end
        tws_pkg::ST_RACK: begin
          if (scl_fall) begin
            state <= master_ack ? tws_pkg::ST_RDATA : tws_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= tws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt <= 4'h0;
    end else if (bus_cond || byte_end) begin
      cnt <= 4'h0;
    end else if (take_bit || ((state == tws_pkg::ST_RDATA) && scl_rise)) begin
      cnt <= cnt + 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift <= 8'h00;
    end else if (take_bit) begin
      shift <= {shift[6:0], sda_f};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rw <= 1'b0;
    end else if (addr_hit) begin
      rw <= shift[0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ptr <= 8'h00;
    end else if (!bus_cond && (state == tws_pkg::ST_PTR) && byte_end) begin
      ptr <= shift;
    end else if (push) begin
      ptr <= ptr + 8'h01;
    end else if (!bus_cond && (state == tws_pkg::ST_RDATA) && byte_end) begin
      ptr <= ptr + 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx <= 8'h00;
    end else if (load_tx) begin
      tx <= rd_data;
    end else if (!bus_cond && (state == tws_pkg::ST_RDATA) && scl_fall && !byte_end) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      master_ack <= 1'b0;
    end else if (!bus_cond && (state == tws_pkg::ST_RACK) && scl_rise) begin
      master_ack <= !sda_f;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      oe <= 1'b0;
    end else if (bus_cond) begin
      oe <= 1'b0;
    end else begin
      case (state)
        tws_pkg::ST_IDLE: begin
          oe <= 1'b0;
        end
        tws_pkg::ST_ADDR: begin
          if (addr_hit) begin
            oe <= 1'b1;
          end
        end
        tws_pkg::ST_PTR: begin
          if (byte_end) begin
            oe <= 1'b1;
          end
        end
        tws_pkg::ST_WDATA: begin
          if (push) begin
            oe <= 1'b1;
          end
        end
        tws_pkg::ST_ADDR_ACK, tws_pkg::ST_RACK: begin
          if (scl_fall) begin
            oe <= load_tx && !rd_data[7];
          end
        end
        tws_pkg::ST_PTR_ACK, tws_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe <= 1'b0;
          end
        end
        tws_pkg::ST_RDATA: begin
          if (byte_end) begin
            oe <= 1'b0;
          end else if (scl_fall) begin
            oe <= !tx[6];
          end
        end
        default: begin
          oe <= 1'b0;
        end
      endcase
    end
  end

  // The image follows every accepted write so reads return what was written.
  tws_regmem #(
    .AW (tws_pkg::REG_AW),
    .DW (tws_pkg::BYTE_BITS)
  ) u_regmem (
    .clk     (CLK),
    .rst     (SYS_RST),
    .wr_en   (push),
    .wr_addr (ptr),
    .wr_data (shift),
    .rd_addr (ptr),
    .rd_data (rd_data)
  );

  tws_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({ptr, shift}),
    .out_valid (WR_VALID),
    .out_ready (WR_READY),
    .out_data  (fifo_out)
  );

  assign WR_ADDR = fifo_out[15:8];
  assign WR_DATA = fifo_out[7:0];

endmodule
`default_nettype wire
